// file: ipr_pkg.sv
// Package for the interrupt priority register bank: offsets, field layouts, reset values
`default_nettype none
package ipr_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] PRIO_CTRL_5_OFFS = 8'h00;
  localparam logic [7:0] PRIO_CTRL_6_OFFS = 8'h04;
  localparam logic [7:0] PRIO_CTRL_7_OFFS = 8'h08;
  localparam logic [7:0] PRIO_CTRL_10_OFFS = 8'h0c;
  localparam logic [7:0] PRIO_CTRL_12_OFFS = 8'h10;
  localparam logic [7:0] PRIO_CTRL_15_OFFS = 8'h14;
  localparam logic [7:0] PRIO_CTRL_16_OFFS = 8'h18;

  // ****************************************************************
  // Field layout and codes
  // ****************************************************************
  localparam int PRIO_W = 3;
  localparam int REG_W = 16;
  localparam int FLD_LO_0 = 0;
  localparam int FLD_LO_4 = 4;
  localparam int FLD_LO_8 = 8;
  localparam int FLD_LO_12 = 12;
  localparam logic [2:0] PRIO_RST = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_MAX = 3'h7;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

  // ****************************************************************
  // Carrier of all priority levels
  // ****************************************************************
  typedef struct packed {
    logic [2:0] capcomp5_event_prio;
    logic [2:0] ext_irq1_prio;
    logic [2:0] capcomp3_timer_prio;
    logic [2:0] uart2_tx_prio;
    logic [2:0] uart2_rx_prio;
    logic [2:0] ext_irq2_prio;
    logic [2:0] capcomp4_timer_prio;
    logic [2:0] capcomp5_timer_prio;
    logic [2:0] serial2_collision_prio;
    logic [2:0] serial2_event_prio;
    logic [2:0] calendar_clock_prio;
    logic [2:0] uart2_error_prio;
    logic [2:0] uart1_error_prio;
  } ipr_prio_t;

  // One enable bit per source, same order as the levels
  typedef struct packed {
    logic capcomp5_event_en;
    logic ext_irq1_en;
    logic capcomp3_timer_en;
    logic uart2_tx_en;
    logic uart2_rx_en;
    logic ext_irq2_en;
    logic capcomp4_timer_en;
    logic capcomp5_timer_en;
    logic serial2_collision_en;
    logic serial2_event_en;
    logic calendar_clock_en;
    logic uart2_error_en;
    logic uart1_error_en;
  } ipr_enable_t;

endpackage
`default_nettype wire

// file: ipr_regs.sv
// Interrupt priority register bank with APB slave
//
// Function
// - Field code 111 gives the source priority 7, the highest.
// - Code 001 gives priority 1; codes between map linearly to 2..6.
// - Code 000 disables the source; it never raises a request.
// - Unimplemented bits always read as zero.
// - Each field resets to binary 100.
// - Register five: capture/compare 5 event priority at bits 10:8.
// - Register five: external interrupt 1 priority at bits 2:0.
// - Register six: capture/compare 3 timer priority at bits 14:12.
// - Register seven: second UART transmit priority at bits 14:12.
// - Register seven: second UART receive priority at bits 10:8.
// - Register seven: external interrupt 2 priority at bits 6:4.
// - Register seven: capture/compare 4 timer priority at bits 2:0.
// - Register ten: capture/compare 5 timer priority at bits 6:4.
// - Register twelve: serial 2 collision at 10:8, event at 6:4.
// - Register fifteen: calendar clock priority at bits 10:8.
// - Register sixteen: second UART error priority at bits 10:8.
// - Register sixteen: first UART error priority at bits 6:4.
//
// Seven software-written priority registers, one aligned word each on APB.
// Each source owns a 3-bit level; the arbiter reads all levels from prio.
// Level zero masks the source, which src_en reports one bit per source.
// Only the field bits are stored; every other bit of a word is tied to zero,
// so unused positions cannot be set by a stray write.
// Writes honour pstrb: a field in bits 15:8 needs lane 1, in 7:0 lane 0.
// pstrb[3:2] and pwdata[31:16] are ignored; the upper half reads zero.
// Unmapped addresses read zero and accept writes without effect or error.
// The slave has no wait states: pready is tied high, pslverr low.
// Read data are captured at the end of the setup phase, so they stand
// through the access phase and until the next read setup.
// Reset is asynchronous and puts every level at binary 100, the middle level.
// A write and a read never share a transfer, so capture and update never race.
// Each register has its own next-value logic and its own flop process,
// so a write to one word can never disturb the levels of another.
//
// The register offsets and register access over APB were left to the implementer.
`default_nettype none
module ipr_regs
  import ipr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Priority levels and source enables to the arbiter
  output ipr_prio_t prio,
  output ipr_enable_t src_en
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic wr_acc;
  logic rd_setup;
  logic [1:0] lane_we;
  logic hit;
  logic [15:0] rd_mux;

  // One write select per register
  logic wr_reg5;
  logic wr_reg6;
  logic wr_reg7;
  logic wr_reg10;
  logic wr_reg12;
  logic wr_reg15;
  logic wr_reg16;

  // Level flops, read data flop and next levels
  ipr_prio_t prio_ff;
  logic [31:0] prdata_ff;
  logic [2:0] nxt_capcomp5_event_prio;
  logic [2:0] nxt_ext_irq1_prio;
  logic [2:0] nxt_capcomp3_timer_prio;
  logic [2:0] nxt_uart2_tx_prio;
  logic [2:0] nxt_uart2_rx_prio;
  logic [2:0] nxt_ext_irq2_prio;
  logic [2:0] nxt_capcomp4_timer_prio;
  logic [2:0] nxt_capcomp5_timer_prio;
  logic [2:0] nxt_serial2_collision_prio;
  logic [2:0] nxt_serial2_event_prio;
  logic [2:0] nxt_calendar_clock_prio;
  logic [2:0] nxt_uart2_error_prio;
  logic [2:0] nxt_uart1_error_prio;

  // Write takes effect in the access phase; lanes from strobes
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign lane_we = pstrb[1:0];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Write decode; an unmapped address selects nothing
  assign wr_reg5 = wr_acc & (paddr == PRIO_CTRL_5_OFFS);
  assign wr_reg6 = wr_acc & (paddr == PRIO_CTRL_6_OFFS);
  assign wr_reg7 = wr_acc & (paddr == PRIO_CTRL_7_OFFS);
  assign wr_reg10 = wr_acc & (paddr == PRIO_CTRL_10_OFFS);
  assign wr_reg12 = wr_acc & (paddr == PRIO_CTRL_12_OFFS);
  assign wr_reg15 = wr_acc & (paddr == PRIO_CTRL_15_OFFS);
  assign wr_reg16 = wr_acc & (paddr == PRIO_CTRL_16_OFFS);

  // Outputs straight from their flops
  assign prio = prio_ff;
  assign prdata = prdata_ff;

  // Field update with byte lanes; only the 3 field bits are written
  function automatic logic [2:0] upd(input logic [2:0] cur, input logic [15:0] wd,
                                     input logic [1:0] lanes, input int lo);
    logic [2:0] res;
    res = cur;
    if (lanes[lo / 8]) begin
      res = wd[lo +: 3];
    end
    return res;
  endfunction

  // ****************************************************************
  // Register five
  // ****************************************************************
  // Next levels: a field takes its bits only when its lane is strobed
  always_comb begin
    nxt_capcomp5_event_prio = prio_ff.capcomp5_event_prio;
    nxt_ext_irq1_prio = prio_ff.ext_irq1_prio;
    if (wr_reg5) begin
      nxt_capcomp5_event_prio = upd(prio_ff.capcomp5_event_prio, pwdata[15:0],
                                    lane_we, FLD_LO_8);
      nxt_ext_irq1_prio = upd(prio_ff.ext_irq1_prio, pwdata[15:0],
                              lane_we, FLD_LO_0);
    end
  end

  // Level flops, binary 100 at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff.capcomp5_event_prio <= PRIO_RST;
      prio_ff.ext_irq1_prio <= PRIO_RST;
    end else begin
      prio_ff.capcomp5_event_prio <= nxt_capcomp5_event_prio;
      prio_ff.ext_irq1_prio <= nxt_ext_irq1_prio;
    end
  end

  // ****************************************************************
  // Register six
  // ****************************************************************
  // Next level: only bits 14:12 are stored
  always_comb begin
    nxt_capcomp3_timer_prio = prio_ff.capcomp3_timer_prio;
    if (wr_reg6) begin
      nxt_capcomp3_timer_prio = upd(prio_ff.capcomp3_timer_prio, pwdata[15:0],
                                    lane_we, FLD_LO_12);
    end
  end

  // Level flop, binary 100 at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff.capcomp3_timer_prio <= PRIO_RST;
    end else begin
      prio_ff.capcomp3_timer_prio <= nxt_capcomp3_timer_prio;
    end
  end

  // ****************************************************************
  // Register seven
  // ****************************************************************
  // Next levels: four fields, two in each lane
  always_comb begin
    nxt_uart2_tx_prio = prio_ff.uart2_tx_prio;
    nxt_uart2_rx_prio = prio_ff.uart2_rx_prio;
    nxt_ext_irq2_prio = prio_ff.ext_irq2_prio;
    nxt_capcomp4_timer_prio = prio_ff.capcomp4_timer_prio;
    if (wr_reg7) begin
      nxt_uart2_tx_prio = upd(prio_ff.uart2_tx_prio, pwdata[15:0],
                              lane_we, FLD_LO_12);
      nxt_uart2_rx_prio = upd(prio_ff.uart2_rx_prio, pwdata[15:0],
                              lane_we, FLD_LO_8);
      nxt_ext_irq2_prio = upd(prio_ff.ext_irq2_prio, pwdata[15:0],
                              lane_we, FLD_LO_4);
      nxt_capcomp4_timer_prio = upd(prio_ff.capcomp4_timer_prio, pwdata[15:0],
                                    lane_we, FLD_LO_0);
    end
  end

  // Level flops, binary 100 at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff.uart2_tx_prio <= PRIO_RST;
      prio_ff.uart2_rx_prio <= PRIO_RST;
      prio_ff.ext_irq2_prio <= PRIO_RST;
      prio_ff.capcomp4_timer_prio <= PRIO_RST;
    end else begin
      prio_ff.uart2_tx_prio <= nxt_uart2_tx_prio;
      prio_ff.uart2_rx_prio <= nxt_uart2_rx_prio;
      prio_ff.ext_irq2_prio <= nxt_ext_irq2_prio;
      prio_ff.capcomp4_timer_prio <= nxt_capcomp4_timer_prio;
    end
  end

  // ****************************************************************
  // Register ten
  // ****************************************************************
  // Next level: only bits 6:4 are stored
  always_comb begin
    nxt_capcomp5_timer_prio = prio_ff.capcomp5_timer_prio;
    if (wr_reg10) begin
      nxt_capcomp5_timer_prio = upd(prio_ff.capcomp5_timer_prio, pwdata[15:0],
                                    lane_we, FLD_LO_4);
    end
  end

  // Level flop, binary 100 at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff.capcomp5_timer_prio <= PRIO_RST;
    end else begin
      prio_ff.capcomp5_timer_prio <= nxt_capcomp5_timer_prio;
    end
  end

  // ****************************************************************
  // Register twelve
  // ****************************************************************
  // Next levels: collision in the upper lane, event in the lower
  always_comb begin
    nxt_serial2_collision_prio = prio_ff.serial2_collision_prio;
    nxt_serial2_event_prio = prio_ff.serial2_event_prio;
    if (wr_reg12) begin
      nxt_serial2_collision_prio = upd(prio_ff.serial2_collision_prio, pwdata[15:0],
                                       lane_we, FLD_LO_8);
      nxt_serial2_event_prio = upd(prio_ff.serial2_event_prio, pwdata[15:0],
                                   lane_we, FLD_LO_4);
    end
  end

  // Level flops, binary 100 at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff.serial2_collision_prio <= PRIO_RST;
      prio_ff.serial2_event_prio <= PRIO_RST;
    end else begin
      prio_ff.serial2_collision_prio <= nxt_serial2_collision_prio;
      prio_ff.serial2_event_prio <= nxt_serial2_event_prio;
    end
  end

  // ****************************************************************
  // Register fifteen
  // ****************************************************************
  // Next level: only bits 10:8 are stored
  always_comb begin
    nxt_calendar_clock_prio = prio_ff.calendar_clock_prio;
    if (wr_reg15) begin
      nxt_calendar_clock_prio = upd(prio_ff.calendar_clock_prio, pwdata[15:0],
                                    lane_we, FLD_LO_8);
    end
  end

  // Level flop, binary 100 at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff.calendar_clock_prio <= PRIO_RST;
    end else begin
      prio_ff.calendar_clock_prio <= nxt_calendar_clock_prio;
    end
  end

  // ****************************************************************
  // Register sixteen
  // ****************************************************************
  // Next levels: second UART error upper lane, first UART error lower
  always_comb begin
    nxt_uart2_error_prio = prio_ff.uart2_error_prio;
    nxt_uart1_error_prio = prio_ff.uart1_error_prio;
    if (wr_reg16) begin
      nxt_uart2_error_prio = upd(prio_ff.uart2_error_prio, pwdata[15:0],
                                 lane_we, FLD_LO_8);
      nxt_uart1_error_prio = upd(prio_ff.uart1_error_prio, pwdata[15:0],
                                 lane_we, FLD_LO_4);
    end
  end

  // Level flops, binary 100 at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff.uart2_error_prio <= PRIO_RST;
      prio_ff.uart1_error_prio <= PRIO_RST;
    end else begin
      prio_ff.uart2_error_prio <= nxt_uart2_error_prio;
      prio_ff.uart1_error_prio <= nxt_uart1_error_prio;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Assemble read word; every bit not placed stays zero
  always_comb begin
    rd_mux = 16'h0000;
    hit = 1'b1;
    case (paddr)
      PRIO_CTRL_5_OFFS: begin
        rd_mux[FLD_LO_8 +: PRIO_W] = prio.capcomp5_event_prio;
        rd_mux[FLD_LO_0 +: PRIO_W] = prio.ext_irq1_prio;
      end
      PRIO_CTRL_6_OFFS: begin
        rd_mux[FLD_LO_12 +: PRIO_W] = prio.capcomp3_timer_prio;
      end
      PRIO_CTRL_7_OFFS: begin
        rd_mux[FLD_LO_12 +: PRIO_W] = prio.uart2_tx_prio;
        rd_mux[FLD_LO_8 +: PRIO_W] = prio.uart2_rx_prio;
        rd_mux[FLD_LO_4 +: PRIO_W] = prio.ext_irq2_prio;
        rd_mux[FLD_LO_0 +: PRIO_W] = prio.capcomp4_timer_prio;
      end
      PRIO_CTRL_10_OFFS: begin
        rd_mux[FLD_LO_4 +: PRIO_W] = prio.capcomp5_timer_prio;
      end
      PRIO_CTRL_12_OFFS: begin
        rd_mux[FLD_LO_8 +: PRIO_W] = prio.serial2_collision_prio;
        rd_mux[FLD_LO_4 +: PRIO_W] = prio.serial2_event_prio;
      end
      PRIO_CTRL_15_OFFS: begin
        rd_mux[FLD_LO_8 +: PRIO_W] = prio.calendar_clock_prio;
      end
      PRIO_CTRL_16_OFFS: begin
        rd_mux[FLD_LO_8 +: PRIO_W] = prio.uart2_error_prio;
        rd_mux[FLD_LO_4 +: PRIO_W] = prio.uart1_error_prio;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // Read data registered in the setup phase, valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= UNMAPPED_RDATA;
    end else if (rd_setup) begin
      prdata_ff <= hit ? {16'h0000, rd_mux} : UNMAPPED_RDATA;
    end
  end

  // ****************************************************************
  // Source enables: level 000 masks, any other level 1..7 is live
  // ****************************************************************
  assign src_en = ipr_enable_t'({
    prio.capcomp5_event_prio != PRIO_OFF, prio.ext_irq1_prio != PRIO_OFF,
    prio.capcomp3_timer_prio != PRIO_OFF, prio.uart2_tx_prio != PRIO_OFF,
    prio.uart2_rx_prio != PRIO_OFF, prio.ext_irq2_prio != PRIO_OFF,
    prio.capcomp4_timer_prio != PRIO_OFF, prio.capcomp5_timer_prio != PRIO_OFF,
    prio.serial2_collision_prio != PRIO_OFF, prio.serial2_event_prio != PRIO_OFF,
    prio.calendar_clock_prio != PRIO_OFF, prio.uart2_error_prio != PRIO_OFF,
    prio.uart1_error_prio != PRIO_OFF});

endmodule
`default_nettype wire

// file: ipr_regs_assertions.sv
// Port checker for the interrupt priority register bank
`default_nettype none
module ipr_regs_assertions
  import ipr_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Levels and enables
  input wire ipr_prio_t prio,
  input wire ipr_enable_t src_en
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  // Write access phase
  assign wr = psel && penable && pwrite;
  a_zero_wait_ok: assert property (pready && !pslverr)
    else $error("APB answer not ready and okay");
  a_rdata_upper: assert property (prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_reset_level: assert property ($rose(presetn) |-> prio == {13{PRIO_RST}})
    else $error("levels not 100 after reset");
  a_off_disables: assert property (src_en.uart2_tx_en == (prio.uart2_tx_prio != PRIO_OFF))
    else $error("enable does not follow level zero");
  a_irq1_write: assert property (wr && paddr == PRIO_CTRL_5_OFFS && pstrb[0]
    |=> prio.ext_irq1_prio == $past(pwdata[2:0]))
    else $error("external 1 level not written");
  a_tx_write: assert property (wr && paddr == PRIO_CTRL_7_OFFS && pstrb[1]
    |=> prio.uart2_tx_prio == $past(pwdata[14:12]))
    else $error("uart2 transmit level not written");
  a_reg5_read: assert property (psel && !penable && !pwrite && paddr == PRIO_CTRL_5_OFFS
    |=> prdata[15:0] == {5'h00, $past(prio.capcomp5_event_prio), 5'h00,
    $past(prio.ext_irq1_prio)})
    else $error("register five read image wrong");
  a_levels_hold: assert property (!(wr && paddr <= PRIO_CTRL_16_OFFS) |=> $stable(prio))
    else $error("levels changed without a mapped write");
  // Main scenarios reached
  cover property (wr && paddr == PRIO_CTRL_7_OFFS);
  cover property (src_en == '0);
  cover property (prio.uart2_tx_prio == PRIO_MAX);
endmodule
bind ipr_regs ipr_regs_assertions u_ipr_regs_assertions (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .prio(prio),
  .src_en(src_en));
`default_nettype wire

// file: ipr_regs_tb.sv
// Self-checking testbench of the interrupt priority register bank
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module ipr_regs_tb
  import ipr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Signals, tables and design
  // ****************************************************************
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr;
  ipr_prio_t prio;
  ipr_enable_t src_en;
  int error_cnt = 0, check_count = 0;
  logic [7:0] offs [7] = '{PRIO_CTRL_5_OFFS, PRIO_CTRL_6_OFFS, PRIO_CTRL_7_OFFS,
    PRIO_CTRL_10_OFFS, PRIO_CTRL_12_OFFS, PRIO_CTRL_15_OFFS, PRIO_CTRL_16_OFFS};
  logic [15:0] rst_img [7] = '{16'h0404, 16'h4000, 16'h4444, 16'h0040, 16'h0440,
    16'h0400, 16'h0440};
  logic [15:0] pat [7] = '{16'h0201, 16'h3000, 16'h4567, 16'h0010, 16'h0230,
    16'h0600, 16'h0570};
  ipr_regs u_ipr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prio(prio), .src_en(src_en));
  // Clock of 10 ns
  always #5 pclk = ~pclk;
  // ****************************************************************
  // Bus tasks and scenarios
  // ****************************************************************
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    apb(a, 1'b0, 32'h0000_0000, 4'h0);
    `CHK("rdata", {16'h0000, e}, rd)
  endtask
  task automatic t_reset;
    for (int i = 0; i < 7; i++) rd_chk(offs[i], rst_img[i]);
    `CHK("prio", {13{PRIO_RST}}, prio)
    $display("reset test done");
  endtask
  task automatic t_layout;
    logic [15:0] m;
    ipr_prio_t el;
    el = {3'h2, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3, 3'h6, 3'h5, 3'h7};
    for (int i = 0; i < 7; i++) begin
      m = rst_img[i] | (rst_img[i] >> 1) | (rst_img[i] >> 2);
      apb(offs[i], 1'b1, {16'hffff, pat[i] | ~m}, 4'hf);
      rd_chk(offs[i], pat[i]);
    end
    `CHK("prio upper", el[38:18], prio[38:18])
    `CHK("prio lower", el[17:0], prio[17:0])
    $display("layout test done");
  endtask
  task automatic t_codes;
    logic [2:0] v;
    for (int c = 0; c < 8; c++) begin
      v = c[2:0];
      apb(PRIO_CTRL_7_OFFS, 1'b1, {16'h0000, 1'b0, v, 1'b0, v, 1'b0, v, 1'b0, v}, 4'h3);
      @(negedge pclk);
      `CHK("tx level", v, prio.uart2_tx_prio)
      `CHK("irq2 enable", v != 3'h0, src_en.ext_irq2_en)
    end
    $display("codes test done");
  endtask
  task automatic t_strobe_reset;
    apb(PRIO_CTRL_16_OFFS, 1'b1, 32'h0000_0000, 4'h1);
    rd_chk(PRIO_CTRL_16_OFFS, 16'h0500);
    apb(8'h1c, 1'b1, 32'hffff_ffff, 4'hf);
    rd_chk(8'h1c, 16'h0000);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("prio", {13{PRIO_RST}}, prio)
    $display("strobe and reset test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_layout;
    t_codes;
    t_strobe_reset;
    end_sim;
  end
  // Watchdog against a hang
  initial begin
    #100000;
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
